// [verilog/sxt_timing.sv]
`timescale 1ns/1ps
`default_nettype none
module sxt_timing (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic op_valid_i,
	input wire logic [1:0] op_bytes_i,
	input wire logic op_branch_i,
	input wire logic [1:0] op_extra_i,
	input wire logic op_xmove_i,
	input wire logic op_xwrite_i,
	input wire logic [sxt_pkg::SXT_ADDR_W-1:0] op_xaddr_i,
	input wire logic [sxt_pkg::SXT_DATA_W-1:0] op_wdata_i,
	input wire logic ctl_wr_i,
	input wire logic [7:0] ctl_wdata_i,
	input wire logic [sxt_pkg::SXT_DATA_W-1:0] xdata_i,
	output logic op_ack_o,
	output logic fetch_o,
	output logic instr_done_o,
	output logic cpu_hold_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [sxt_pkg::SXT_ADDR_W-1:0] xaddr_o,
	output logic [sxt_pkg::SXT_DATA_W-1:0] xdata_o,
	output logic xdata_oe_o,
	output logic [sxt_pkg::SXT_DATA_W-1:0] rdata_o,
	output logic [2:0] stretch_o
);
	import sxt_pkg::*;

	typedef struct packed {
		sxt_run_e run;
		logic [3:0] mc;
		logic [3:0] total;
		logic [1:0] nfetch;
		logic is_x;
		logic is_wr;
		logic [2:0] sl;
		logic [2:0] ctl;
		logic ack;
		logic fetch;
		logic done;
		logic hold;
		logic rd_n;
		logic wr_n;
		logic rd_end;
		logic [SXT_ADDR_W-1:0] xaddr;
		logic [SXT_DATA_W-1:0] xdata;
		logic xoe;
		logic [SXT_DATA_W-1:0] sync1;
		logic [SXT_DATA_W-1:0] sync2;
		logic [SXT_DATA_W-1:0] rdata;
	} sxt_core_s;

	sxt_core_s st;
	sxt_core_s next_st;
	sxt_phase_e phase;

	sxt_phase_ring u_ring (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.phase_o(phase)
	);

	// Cycle count of an ordinary instruction: one per byte, one more for a
	// jump or call, plus any extra the decoder asks for, held to five.
	function automatic logic [3:0] cycles_of(input logic [1:0] bytes,
		input logic branch, input logic [1:0] extra);
		logic [3:0] sum;
		sum = {2'h0, bytes} + {3'h0, branch} + {2'h0, extra};
		if (sum == 4'h0) begin
			sum = 4'h1;
		end
		if (sum > SXT_MAX_CYCLES) begin
			sum = SXT_MAX_CYCLES;
		end
		return sum;
	endfunction

	// True when the strobe is active at clock state ph of machine cycle mc.
	// Stretch 0 uses C2..C3 of the access cycle; stretch s starts at its C3
	// and runs four clocks per step, ending on C2 of the last cycle.
	function automatic logic strobe_on(input logic [3:0] mc, input sxt_phase_e ph,
		input logic [2:0] s);
		logic [5:0] idx;
		logic [5:0] last;
		idx = 6'h00;
		last = 6'h00;
		if (mc < SXT_XMOVE_BASE) begin
			return 1'b0;
		end
		idx = {mc - SXT_XMOVE_BASE, 2'h0} + {4'h0, ph};
		if (s == 3'h0) begin
			return (idx >= SXT_STROBE_S0_FIRST) && (idx <= SXT_STROBE_S0_LAST);
		end
		last = SXT_STROBE_FIRST + {1'b0, s, 2'h0} - 6'h01;
		return (idx >= SXT_STROBE_FIRST) && (idx <= last);
	endfunction

	// Next state: the machine cycle turns over on C4 only, so every cycle of
	// an instruction, stretched or not, is exactly four clocks.
	always_comb begin
		sxt_phase_e nph;
		logic last_mc;
		logic [3:0] nmc;
		nph = PH_C1;
		last_mc = 1'b0;
		nmc = 4'h0;
		next_st = st;
		next_st.ack = 1'b0;
		next_st.done = 1'b0;
		nph = sxt_phase_e'(phase + 2'h1);
		last_mc = (st.run == RUN_IDLE) || (st.mc == st.total);
		// The field only loads; a running access keeps its latched copy.
		if (ctl_wr_i) begin
			next_st.ctl = ctl_wdata_i[SXT_STRETCH_MSB:SXT_STRETCH_LSB];
		end
		if (phase == PH_C4) begin
			if (st.run == RUN_EXEC && last_mc) begin
				next_st.done = 1'b1;
			end
			if (last_mc) begin
				if (op_valid_i) begin
					next_st.run = RUN_EXEC;
					next_st.ack = 1'b1;
					next_st.mc = 4'h1;
					next_st.is_x = op_xmove_i;
					next_st.is_wr = op_xwrite_i;
					next_st.xaddr = op_xaddr_i;
					next_st.xdata = op_wdata_i;
					if (op_xmove_i) begin
						next_st.sl = st.ctl;
						next_st.total = {1'b0, st.ctl} + SXT_XMOVE_BASE;
						next_st.nfetch = 2'h1;
					end else begin
						next_st.total = cycles_of(op_bytes_i, op_branch_i, op_extra_i);
						next_st.nfetch = (op_bytes_i == 2'h0) ? 2'h1 : op_bytes_i;
					end
				end else begin
					next_st.run = RUN_IDLE;
					next_st.is_x = 1'b0;
					next_st.mc = 4'h0;
				end
			end else begin
				next_st.mc = st.mc + 4'h1;
			end
		end
		nmc = next_st.mc;
		// One fetch strobe at C1 of each byte-carrying cycle, never more.
		next_st.fetch = (nph == PH_C1) && (next_st.run == RUN_EXEC) &&
			(nmc <= {2'h0, next_st.nfetch});
		// Extra cycles of a stretched access keep the CPU frozen.
		next_st.hold = next_st.is_x && (next_st.run == RUN_EXEC) &&
			(nmc > SXT_XMOVE_BASE);
		next_st.rd_n = !(next_st.is_x && !next_st.is_wr && strobe_on(nmc, nph, next_st.sl));
		next_st.wr_n = !(next_st.is_x && next_st.is_wr && strobe_on(nmc, nph, next_st.sl));
		// Data is driven for the whole access phase of a write.
		next_st.xoe = next_st.is_x && next_st.is_wr && (nmc >= SXT_XMOVE_BASE);
		next_st.sync1 = xdata_i;
		next_st.sync2 = st.sync1;
		// Read data is taken one clock after the strobe closes. Through the two
		// stage synchroniser that is the pin value of the strobe's last but one
		// clock, so even the two clock strobe of stretch 0 is sampled while low.
		next_st.rd_end = !st.rd_n && next_st.rd_n;
		if (st.rd_end) begin
			next_st.rdata = st.sync2;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.run <= RUN_IDLE;
			st.ctl <= SXT_STRETCH_RESET;
			st.sl <= SXT_STRETCH_RESET;
			st.rd_n <= 1'b1;
			st.wr_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state flops.
	assign op_ack_o = st.ack;
	assign fetch_o = st.fetch;
	assign instr_done_o = st.done;
	assign cpu_hold_o = st.hold;
	assign rd_n_o = st.rd_n;
	assign wr_n_o = st.wr_n;
	assign xaddr_o = st.xaddr;
	assign xdata_o = st.xdata;
	assign xdata_oe_o = st.xoe;
	assign rdata_o = st.rdata;
	assign stretch_o = st.ctl;

	// Helper counters: clocks of the current instruction and strobe width.
	logic [5:0] instr_clks;
	logic [5:0] strobe_clks;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			instr_clks <= 6'h00;
			strobe_clks <= 6'h00;
		end else begin
			instr_clks <= (st.ack) ? 6'h01 : instr_clks + 6'h01;
			strobe_clks <= (!rd_n_o || !wr_n_o) ? strobe_clks + 6'h01 : 6'h00;
		end
	end

	sequence s_strobe_s0;
		!(rd_n_o && wr_n_o) [*2] ##1 (rd_n_o && wr_n_o);
	endsequence

	a_fetch_spacing: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		fetch_o |=> !fetch_o [*3])
		else $error("Two fetches inside one machine cycle.");
	a_fetch_phase: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		fetch_o |-> (phase == PH_C1))
		else $error("Fetch outside state C1.");
	a_stretch_reset: assert property (@(posedge mclk_i)
		$rose(rst_n_i) |-> (stretch_o == 3'h1))
		else $error("Stretch not one after reset.");
	a_stretch_latched: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(st.run == RUN_EXEC && !st.ack) |-> $stable(st.sl))
		else $error("Latched stretch changed mid instruction.");
	a_hold_xmove: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cpu_hold_o |-> (st.is_x && st.mc > 4'h2 && st.sl != 3'h0))
		else $error("CPU held outside a stretched access.");
	a_strobe_s0: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		($fell(rd_n_o && wr_n_o) && st.sl == 3'h0) |-> s_strobe_s0)
		else $error("Stretch zero strobe not two clocks.");
	a_strobe_width: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		($rose(rd_n_o && wr_n_o) && st.sl != 3'h0) |-> (strobe_clks == {1'b0, st.sl, 2'h0}))
		else $error("Stretched strobe width wrong.");
	// The finished instruction is judged by its state one clock before done,
	// since the done edge may already have loaded or cleared the next one.
	a_xmove_length: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(instr_done_o && $past(st.is_x)) |->
		(instr_clks == {1'b0, $past(st.sl), 2'h0} + {SXT_XMOVE_BASE, 2'h0}))
		else $error("External move length wrong.");
	a_instr_length: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(instr_done_o && !$past(st.is_x) && $past(st.run) == RUN_EXEC) |->
		(instr_clks == {$past(st.total), 2'h0}))
		else $error("Instruction length not whole machine cycles.");
endmodule
`default_nettype wire

// [shared/sxt_pkg.sv]
// Summary of operation
// - Machine cycle lasts exactly four clocks.
// - States C1 to C4 run in order.
// - At most one opcode fetch per cycle.
// - Cycles normally equal instruction byte count.
// - Jumps and calls add one cycle.
// - Half of all opcodes take one cycle.
// - Ordinary instructions take one to five cycles.
// - Fetch cycle first, then external access cycle.
// - Stretch comes from control register bits 2-0.
// - External move lasts stretch plus two cycles.
// - Strobe two clocks, else four per step.
// - Stretching freezes CPU, touches nothing else.
// - Stretch resets to one.
package sxt_pkg;
	// Clock states inside one machine cycle.
	typedef enum logic [1:0] {PH_C1, PH_C2, PH_C3, PH_C4} sxt_phase_e;
	// Instruction sequencer states.
	typedef enum logic {RUN_IDLE, RUN_EXEC} sxt_run_e;
	localparam int unsigned SXT_CLOCKS_PER_MC = 4;
	localparam logic [2:0] SXT_STRETCH_RESET = 3'h1;
	localparam int unsigned SXT_STRETCH_LSB = 0;
	localparam int unsigned SXT_STRETCH_MSB = 2;
	localparam logic [3:0] SXT_MAX_CYCLES = 4'h5;
	localparam logic [3:0] SXT_XMOVE_BASE = 4'h2;
	localparam logic [5:0] SXT_STROBE_S0_FIRST = 6'h01;
	localparam logic [5:0] SXT_STROBE_S0_LAST = 6'h02;
	localparam logic [5:0] SXT_STROBE_FIRST = 6'h02;
	localparam int unsigned SXT_ADDR_W = 16;
	localparam int unsigned SXT_DATA_W = 8;
endpackage

// [verilog/sxt_phase_ring.sv]
`timescale 1ns/1ps
`default_nettype none
module sxt_phase_ring (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	output var sxt_pkg::sxt_phase_e phase_o
);
	import sxt_pkg::*;

	typedef struct packed {
		sxt_phase_e phase;
	} sxt_ring_s;

	sxt_ring_s st;
	sxt_ring_s next_st;

	// Free running ring; it never skips or repeats a state.
	always_comb begin
		next_st = st;
		unique case (st.phase)
			PH_C1: next_st.phase = PH_C2;
			PH_C2: next_st.phase = PH_C3;
			PH_C3: next_st.phase = PH_C4;
			PH_C4: next_st.phase = PH_C1;
		endcase
	end

	// Reset parks on C4 so the first cycle after release is a clean C1.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st.phase <= PH_C4;
		end else begin
			st <= next_st;
		end
	end

	assign phase_o = st.phase;

	a_ring_order: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(st.phase == PH_C1) |=> (st.phase == PH_C2) ##1 (st.phase == PH_C3) ##1 (st.phase == PH_C4))
		else $error("Clock states out of order.");
endmodule
`default_nettype wire

// [verif/sxt_xmem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sxt_xmem_model #(parameter int HOLD = 2) (
	input wire logic mclk_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic oe_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:255];
	logic [7:0] last = 8'h00;
	int cnt = 0;
	// Read data is held only HOLD clocks past the strobe, as a real part would do.
	always @(posedge mclk_i) begin
		if (!rd_n_i) begin
			last <= mem[addr_i[7:0]];
			cnt <= HOLD;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		if (!wr_n_i && oe_i) begin
			mem[addr_i[7:0]] <= wdata_i;
		end
	end
	// A released bus shows the inverse of its last byte, so stale data cannot pass.
	assign rdata_o = (!rd_n_i || cnt > 0) ? mem[addr_i[7:0]] : ~last;
endmodule
`default_nettype wire

// [verif/sxt_timing_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sxt_timing_bench;
	import sxt_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic op_valid_i = 1'b0, op_branch_i = 1'b0, op_xmove_i = 1'b0, op_xwrite_i = 1'b0;
	logic ctl_wr_i = 1'b0;
	logic [1:0] op_bytes_i = 2'h1, op_extra_i = 2'h0;
	logic [15:0] op_xaddr_i = 16'h0000, xaddr_o;
	logic [7:0] op_wdata_i = 8'h00, ctl_wdata_i = 8'h00, xdata_i, xdata_o, rdata_o;
	logic op_ack_o, fetch_o, instr_done_o, cpu_hold_o, rd_n_o, wr_n_o, xdata_oe_o;
	logic [2:0] stretch_o;
	int failures = 0, checks_done = 0, nclk, nfet, nstb, nhold;
	// Free-running system clock.
	always #2 mclk_i = ~mclk_i;
	sxt_timing i_sxt_timing (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
		.op_bytes_i(op_bytes_i), .op_branch_i(op_branch_i), .op_extra_i(op_extra_i),
		.op_xmove_i(op_xmove_i), .op_xwrite_i(op_xwrite_i), .op_xaddr_i(op_xaddr_i),
		.op_wdata_i(op_wdata_i), .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i),
		.xdata_i(xdata_i), .op_ack_o(op_ack_o), .fetch_o(fetch_o),
		.instr_done_o(instr_done_o), .cpu_hold_o(cpu_hold_o), .rd_n_o(rd_n_o),
		.wr_n_o(wr_n_o), .xaddr_o(xaddr_o), .xdata_o(xdata_o), .xdata_oe_o(xdata_oe_o),
		.rdata_o(rdata_o), .stretch_o(stretch_o));
	sxt_xmem_model i_sxt_xmem_model (.mclk_i(mclk_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
		.addr_i(xaddr_o), .wdata_i(xdata_o), .oe_i(xdata_oe_o), .rdata_o(xdata_i));
	task automatic chk_num(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			failures++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// Upper bits are set to show that only the low three bits count.
	task automatic set_stretch(input logic [2:0] s);
		@(posedge mclk_i);
		ctl_wr_i <= 1'b1;
		ctl_wdata_i <= {5'h1f, s};
		@(posedge mclk_i);
		ctl_wr_i <= 1'b0;
	endtask
	// Offers one instruction and counts clocks, fetches, strobe and hold until done.
	task automatic run_op(input logic [1:0] b, input logic br, input logic [1:0] ex,
		input logic xm, input logic xw, input logic [7:0] a);
		@(posedge mclk_i);
		op_valid_i <= 1'b1;
		op_bytes_i <= b;
		op_branch_i <= br;
		op_extra_i <= ex;
		op_xmove_i <= xm;
		op_xwrite_i <= xw;
		op_xaddr_i <= {8'h00, a};
		op_wdata_i <= a ^ 8'h5a;
		nclk = 0;
		while (op_ack_o !== 1'b1 && nclk < 20) begin
			@(negedge mclk_i);
			nclk++;
		end
		// A wait limit that runs out is a mismatch in its own right.
		if (op_ack_o !== 1'b1) failures++;
		{nclk, nfet, nstb, nhold} = 0;
		do begin
			nfet += (fetch_o === 1'b1);
			nstb += (rd_n_o === 1'b0 || wr_n_o === 1'b0);
			nhold += (cpu_hold_o === 1'b1);
			@(posedge mclk_i);
			op_valid_i <= 1'b0;
			@(negedge mclk_i);
			nclk++;
		end while (instr_done_o !== 1'b1 && nclk < 60);
		if (instr_done_o !== 1'b1) failures++;
	endtask
	task automatic t_reset;
		chk_val({5'h00, stretch_o}, 8'h01);
		chk_val({6'h00, rd_n_o, wr_n_o}, 8'h03);
		run_op(2'h1, 1'b0, 2'h0, 1'b1, 1'b1, 8'h20);
		chk_num(nclk, 12);
		chk_num(nstb, 4);
	endtask
	// Bytes, branch, extra and expected cycles; the last entry overflows the clamp.
	task automatic t_plain;
		logic [7:0] tab [0:6] = '{8'h41, 8'h82, 8'hc3, 8'ha3, 8'hed, 8'h53, 8'hf5};
		set_stretch(3'h7);
		foreach (tab[i]) begin
			run_op(tab[i][7:6], tab[i][5], tab[i][4:3], 1'b0, 1'b0, 8'h00);
			chk_num(nclk, 4 * tab[i][2:0]);
			chk_num(nfet, tab[i][7:6]);
			chk_num(nstb + nhold, 0);
		end
	endtask
	task automatic t_stretch;
		for (int s = 0; s < 8; s++) begin
			set_stretch(s[2:0]);
			@(negedge mclk_i);
			chk_val({5'h00, stretch_o}, s[7:0]);
			run_op(2'h1, 1'b0, 2'h0, 1'b1, 1'b1, s[7:0]);
			chk_num(nclk, 4 * (s + 2));
			chk_num(nstb, (s == 0) ? 2 : 4 * s);
			chk_num(nhold, 4 * s);
			chk_num(nfet, 1);
			run_op(2'h1, 1'b0, 2'h0, 1'b1, 1'b0, s[7:0]);
			chk_num(nstb, (s == 0) ? 2 : 4 * s);
			chk_val(rdata_o, s[7:0] ^ 8'h5a);
		end
	endtask
	// A new setting written mid-access must wait for the next external move.
	task automatic t_midwrite;
		set_stretch(3'h1);
		fork
			run_op(2'h1, 1'b0, 2'h0, 1'b1, 1'b0, 8'h03);
			begin
				repeat (8) @(posedge mclk_i);
				set_stretch(3'h3);
			end
		join
		chk_num(nstb, 4);
		run_op(2'h1, 1'b0, 2'h0, 1'b1, 1'b0, 8'h03);
		chk_num(nstb, 12);
	endtask
	task automatic summarize;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Main sequence after the reset span.
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(negedge mclk_i);
		t_reset;
		t_plain;
		t_stretch;
		t_midwrite;
		summarize;
	end
	// The tests need about 650 clocks; this cuts a hang well beyond that.
	initial begin
		#100000;
		failures++;
		summarize;
	end
endmodule
`default_nettype wire
